/* common/next_addr_consts.svh */
`ifndef NEXT_ADDR_CONSTS_SVH
`define NEXT_ADDR_CONSTS_SVH
`define RESET_VEC_LO_ADDR 16'h0000
`define RESET_VEC_HI_ADDR 16'h0001
`define TABLE_BASE_ADDR 16'h0040
`define TABLE_IDX_LSB 1
`define TABLE_IDX_MSB 5
`define DISP_SIGN_BIT 7
`define PC_RESET_VALUE 16'h0000
`endif

/* common/next_addr_pkg.sv */
package next_addr_pkg;
  typedef enum logic [2:0] {
    OP_SEQ = 3'b000,
    OP_REL = 3'b001,
    OP_ABS = 3'b010,
    OP_TABLE = 3'b011,
    OP_PAIR = 3'b100
  } op_class_e;
  typedef enum logic [1:0] {
    ST_VEC_LO = 2'b00,
    ST_VEC_HI = 2'b01,
    ST_RUN = 2'b10,
    ST_TBL_HI = 2'b11
  } seq_state_e;
endpackage

/* hw/next_instruction_address_unit.sv */
// Function
// RL1 - sequential: add instruction byte length
// RL2 - relative: displacement plus next instruction address
// RL3 - displacement signed, bit 7 sign-extended
// RL4 - relative form for jump and taken branches
// RL5 - absolute call/jump loads 16-bit target
// RL6 - table call: index bits 1-5, table 40h-7fh
// RL7 - pair jump copies accumulator pair
// RL8 - reset loads vector from 0000h/0001h
// RL9 - 16-bit register holds next address
// RL10 - table entry low byte even; wrap
`include "next_addr_consts.svh"
module next_instruction_address_unit
  import next_addr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic instr_valid_i,
  input wire op_class_e op_class_i,
  input wire logic branch_taken_i,
  input wire logic [2:0] instr_length_i,
  input wire logic [7:0] jump_displacement_i,
  input wire logic [15:0] absolute_target_i,
  input wire logic [7:0] opcode_i,
  input wire logic [15:0] accumulator_pair_i,
  input wire logic [7:0] mem_rdata_i,
  output logic [15:0] program_counter_o,
  output logic [15:0] mem_addr_o,
  output logic mem_rd_o,
  output logic pc_ready_o
);

  ////////////////////////////////////////////////////////////////
  seq_state_e state, next_state;
  logic [15:0] program_counter, next_program_counter;
  logic [15:0] mem_addr, next_mem_addr;
  logic mem_rd, next_mem_rd;
  logic pc_ready, next_pc_ready;
  logic [7:0] low_byte, next_low_byte;
  logic [15:0] follow_addr;
  logic [15:0] rel_target;
  logic [4:0] table_index;

  // address of the instruction after the current one
  assign follow_addr = program_counter + {13'h0000, instr_length_i}; // [RL1]
  assign table_index = opcode_i[`TABLE_IDX_MSB:`TABLE_IDX_LSB]; // [RL6]

  rel_target_adder u_rel (
    .follow_addr_i(follow_addr),
    .jump_displacement_i(jump_displacement_i),
    .target_o(rel_target)
  );

  ////////////////////////////////////////////////////////////////
  // next-value logic: vector fetch, table fetch, pc update
  always_comb begin
    next_state = state;
    next_program_counter = program_counter;
    next_mem_addr = mem_addr;
    next_mem_rd = 1'b0;
    next_low_byte = low_byte;
    case (state)
      ST_VEC_LO: begin
        next_low_byte = mem_rdata_i;
        next_mem_addr = `RESET_VEC_HI_ADDR; // [RL8]
        next_mem_rd = 1'b1;
        next_state = ST_VEC_HI;
      end
      ST_VEC_HI: begin
        next_program_counter = {mem_rdata_i, low_byte}; // [RL8]
        next_state = ST_RUN;
      end
      ST_RUN: begin
        if (instr_valid_i) begin
          case (op_class_i)
            OP_REL: begin
              if (branch_taken_i) begin
                next_program_counter = rel_target; // [RL4]
              end else begin
                next_program_counter = follow_addr; // [RL1]
              end
            end
            OP_ABS: next_program_counter = absolute_target_i; // [RL5]
            OP_TABLE: begin
              // low byte first at even address
              next_mem_addr = `TABLE_BASE_ADDR + {10'h000, table_index, 1'b0}; // [RL10]
              next_mem_rd = 1'b1;
              next_state = ST_TBL_HI;
            end
            OP_PAIR: next_program_counter = accumulator_pair_i; // [RL7]
            default: next_program_counter = follow_addr; // [RL1]
          endcase
        end
      end
      ST_TBL_HI: begin
        if (mem_addr[0] == 1'b0) begin
          // low byte arriving, fetch the odd one
          next_low_byte = mem_rdata_i;
          next_mem_addr = mem_addr + 16'h0001; // [RL10]
          next_mem_rd = 1'b1;
        end else begin
          next_program_counter = {mem_rdata_i, low_byte}; // [RL6]
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_VEC_LO;
    endcase
    // ready flag registered so the output comes from a flop
    next_pc_ready = (next_state == ST_RUN) ? 1'b1 : 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // registers, frozen while clock enable is low
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_VEC_LO;
      program_counter <= `PC_RESET_VALUE; // [RL9]
      mem_addr <= `RESET_VEC_LO_ADDR; // [RL8]
      mem_rd <= 1'b1;
      low_byte <= 8'h00;
      pc_ready <= 1'b0;
    end else if (clk_en_i) begin
      pc_ready <= next_pc_ready;
      state <= next_state;
      program_counter <= next_program_counter; // [RL9]
      mem_addr <= next_mem_addr;
      mem_rd <= next_mem_rd;
      low_byte <= next_low_byte;
    end
  end

  // outputs straight from flip-flops
  assign program_counter_o = program_counter;
  assign mem_addr_o = mem_addr;
  assign mem_rd_o = mem_rd;
  assign pc_ready_o = pc_ready;
endmodule

/* hw/rel_target_adder.sv */
`include "next_addr_consts.svh"
module rel_target_adder
  import next_addr_pkg::*;
(
  input wire logic [15:0] follow_addr_i,
  input wire logic [7:0] jump_displacement_i,
  output logic [15:0] target_o
);
  logic [15:0] disp_ext;
  // sign-extend displacement, sum wraps at 16 bits
  always_comb begin
    disp_ext = {{8{jump_displacement_i[`DISP_SIGN_BIT]}}, jump_displacement_i}; // [RL3]
    target_o = follow_addr_i + disp_ext; // [RL2] [RL10]
  end
endmodule

/* verification/next_addr_mem.sv */
module next_addr_mem (
  input wire logic [15:0] mem_addr_i,
  input wire logic mem_rd_i,
  output logic [7:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [7:0] b = mem_addr_i[7:0] ^ mem_addr_i[15:8] ^ 8'h5c;
  // byte per address while strobed, inverted junk otherwise
  assign mem_rdata_o = mem_rd_i ? b : ~b;
endmodule

/* verification/next_addr_sva.sv */
module next_addr_sva
  import next_addr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic instr_valid_i,
  input wire op_class_e op_class_i,
  input wire logic branch_taken_i,
  input wire logic [2:0] instr_length_i,
  input wire logic [7:0] jump_displacement_i,
  input wire logic [15:0] absolute_target_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic [15:0] program_counter_o,
  input wire logic mem_rd_o,
  input wire logic pc_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // accept strobe and derived targets
  wire a = pc_ready_o && instr_valid_i;
  wire t = branch_taken_i;
  wire [2:0] o = op_class_i;
  wire [15:0] pc = program_counter_o;
  wire [15:0] nx = pc + {13'h0000, instr_length_i};
  wire [15:0] sx = {{8{jump_displacement_i[7]}}, jump_displacement_i};
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence tbl; a && o == OP_TABLE; endsequence
  sequence word; pc == {$past(mem_rdata_i), $past(mem_rdata_i, 2)}; endsequence
  AST_SEQ: assert property (a && o == OP_SEQ |=> pc == $past(nx)) else $error("seq");
  AST_RELT: assert property (a && o == OP_REL && t |=> pc == $past(nx) + $past(sx))
    else $error("rel");
  AST_RELN: assert property (a && o == OP_REL && !t |=> pc == $past(nx)) else $error("nt");
  AST_ABS: assert property (a && o == OP_ABS |=> pc == $past(absolute_target_i))
    else $error("abs");
  AST_TWALK: assert property (tbl |=> (mem_rd_o && !pc_ready_o)[*2] ##1 pc_ready_o)
    else $error("walk");
  AST_TLOAD: assert property (tbl |-> ##3 word) else $error("tbl");
  AST_RST: assert property ($fell(rst_i) |-> ##2 (word and pc_ready_o)) else $error("rst");
  AST_HOLD: assert property (pc_ready_o && !instr_valid_i |=> $stable(pc)) else $error("h");
  AST_FREEZE: assert property (!clk_en_i |=> $stable(pc)) else $error("freeze");
endmodule

/* verification/next_instruction_address_unit_tb.sv */
module next_instruction_address_unit_tb
  import next_addr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = '0, rst_i = '1, clk_en_i = '1, instr_valid_i = '0, branch_taken_i = '0;
  op_class_e op_class_i = OP_SEQ;
  logic [2:0] instr_length_i = '0;
  logic [7:0] jump_displacement_i = '0, opcode_i = '0, mem_rdata_i;
  logic [15:0] absolute_target_i = '0, accumulator_pair_i = '0, program_counter_o, mem_addr_o;
  logic mem_rd_o, pc_ready_o;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  next_instruction_address_unit u_next_instruction_address_unit (.*);
  next_addr_mem u_next_addr_mem (.mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
    .mem_rdata_o(mem_rdata_i));
  // clock and run limit
  initial forever #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (++cyc == 600) begin
    error_cnt++;
    complete_run();
  end
  task complete_run;
    $display("mismatches %0d compares %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(string n, logic [15:0] e);
    samples_checked++;
    if (program_counter_o !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, program_counter_o);
    end
  endtask
  task chka(string n, logic [15:0] e);
    samples_checked++;
    if (mem_addr_o !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, mem_addr_o);
    end
  endtask
  task issue(op_class_e o, logic [2:0] l, logic [7:0] d);
    @(negedge clk_sys_i);
    op_class_i = o;
    instr_length_i = l;
    jump_displacement_i = d;
    instr_valid_i = 1'h1;
    @(negedge clk_sys_i);
    instr_valid_i = 1'h0;
    repeat (4) if (pc_ready_o !== 1'h1) @(negedge clk_sys_i);
  endtask
  task t_vec;
    rst_i = 1'h1;
    repeat (16) @(negedge clk_sys_i);
    rst_i = 1'h0;
    repeat (4) if (pc_ready_o !== 1'h1) @(negedge clk_sys_i);
    chk("vec", 16'h5d5c);
  endtask
  task t_branch;
    absolute_target_i = 16'hfffe;
    issue(OP_ABS, 3'h3, 8'h00);
    chk("abs", 16'hfffe);
    branch_taken_i = 1'h1;
    issue(OP_REL, 3'h2, 8'h80);
    chk("back", 16'hff80);
    issue(OP_REL, 3'h2, 8'h7f);
    chk("wrap", 16'h0001);
    branch_taken_i = 1'h0;
    issue(OP_REL, 3'h2, 8'h7f);
    chk("fall", 16'h0003);
    issue(OP_SEQ, 3'h3, 8'h7f);
    chk("seq", 16'h0006);
  endtask
  task t_indirect;
    accumulator_pair_i = 16'ha55a;
    issue(OP_PAIR, 3'h1, 8'h00);
    chk("pair", 16'ha55a);
    opcode_i = 8'hff;
    issue(OP_TABLE, 3'h1, 8'h00);
    chk("tbl", 16'h2322);
    chka("taddr", 16'h007f);
  endtask
  task t_freeze;
    clk_en_i = 1'h0;
    absolute_target_i = 16'h1234;
    issue(OP_ABS, 3'h3, 8'h00);
    chk("freeze", 16'h2322);
    clk_en_i = 1'h1;
  endtask
  initial begin
    t_vec();
    t_branch();
    t_indirect();
    t_freeze();
    t_vec();
    complete_run();
  end
endmodule
bind next_instruction_address_unit next_addr_sva u_next_addr_sva (.*);
